// File: core/mpr_pkg.sv
// Constants shared by the multifunction pin router
package mpr_pkg;
  localparam int unsigned NPINS     = 8;
  localparam int unsigned MODE_BIT  = 7;
  localparam logic [11:0] FSEL_BASE = 12'h200;
  localparam logic [11:0] FSEL_LAST = 12'h207;
  localparam logic [7:0]  FSEL_RST  = 8'h00;

  // Output-mode function codes
  localparam int unsigned OC_HIGH   = 1;
  localparam int unsigned OC_DIV    = 2;
  localparam int unsigned OC_WD     = 3;
  localparam int unsigned OC_UPL    = 4;
  localparam int unsigned OC_DNL    = 5;
  localparam int unsigned OC_LFLT   = 6;
  localparam int unsigned OC_LOCK   = 7;
  localparam int unsigned OC_CAL    = 8;
  localparam int unsigned OC_STBL   = 11;
  localparam int unsigned OC_LOOP   = 16;
  localparam int unsigned NLOOP     = 11;
  localparam int unsigned OC_FAULT  = 32;
  localparam int unsigned OC_VALID  = 48;
  localparam int unsigned OC_ACT    = 64;
  localparam int unsigned OC_SYNC   = 80;
  localparam int unsigned NCODES    = 128;

  // Input-mode function codes
  localparam int unsigned IC_SYS    = 1;
  localparam int unsigned IC_LOOP   = 16;
  localparam int unsigned IC_OVR    = 32;
  localparam int unsigned IC_TMO    = 48;
  localparam int unsigned IC_EN     = 64;
  localparam int unsigned IC_ENALL  = 68;
  localparam int unsigned IC_SYNC   = 69;

  // Control vector layout
  localparam int unsigned CI_SYS    = 0;
  localparam int unsigned CI_LOOP   = 5;
  localparam int unsigned CI_OVR    = 10;
  localparam int unsigned CI_TMO    = 18;
  localparam int unsigned CI_EN     = 26;
  localparam int unsigned NCTL      = 30;

  // Timing in system clock periods
  localparam logic [3:0]  DIV_LAST  = 4'hf;
  localparam logic [5:0]  WD_CYC    = 6'h20;

  typedef enum logic {
    MPR_STRAP = 1'b0,
    MPR_RUN   = 1'b1
  } mpr_phase_t;
endpackage : mpr_pkg

// File: core/mpr_router.sv
// Multifunction pin router: per-pin function select, muxing and priority
// Summary of operation
// - Each of eight pins has a select register; top bit one makes it output.
// - Top bit zero makes the pin an input driving a chosen control.
// - Low seven select bits form the function code.
// - Output codes 0,1,2,3,4-6,7,8,11,80 give levels, clock/32, watchdog, status.
// - Output codes 16 to 26 show the eleven loop status flags in order.
// - Output codes 32-39 fault, 48-55 valid, 64-71 active per reference.
// - Input code 0 unused; 1-5 update, power-down, watchdog, irq, history reset.
// - Input codes 16-20 holdover, free-run, phase offset reset, up, down.
// - Input codes 32-39 override the monitor of each reference in order.
// - Input codes 48-55 force each reference validation timeout to expire.
// - Input 64-67 enable one channel, 68 all four, 69 requests output sync.
// - Several pins on one control: lowest pin index wins, others ignored.
// - Strap levels are taken only just after reset; then pins are programmable.
// - Sync request from a pin fires on that pin's falling edge.
// - Watchdog report on a pin is a pulse of 32 system clock periods.
`timescale 1ns/1ps
`default_nettype none
module mpr_router
  import mpr_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic [7:0]        pin_in,
  output var  logic [7:0]        pin_out,
  output var  logic [7:0]        pin_oe,
  input  wire logic              host_wr,
  input  wire logic              host_rd,
  input  wire logic [11:0]       host_addr,
  input  wire logic [7:0]        host_wdata,
  output var  logic [7:0]        host_rdata,
  input  wire logic              loader_wr,
  input  wire logic [11:0]       loader_addr,
  input  wire logic [7:0]        loader_wdata,
  output var  logic [7:0]        strap_value,
  output var  logic              strap_valid,
  input  wire logic              watchdog_timeout,
  input  wire logic              upload_busy,
  input  wire logic              download_busy,
  input  wire logic              loader_fault,
  input  wire logic              system_clock_source_lock,
  input  wire logic              system_clock_source_cal_busy,
  input  wire logic              system_clock_source_stable,
  input  wire logic [NLOOP-1:0]  loop_status,
  input  wire logic [7:0]        ref_fault,
  input  wire logic [7:0]        ref_valid,
  input  wire logic [7:0]        ref_active,
  input  wire logic              dist_sync_status,
  output var  logic [NCTL-1:0]   ctl_owned,
  output var  logic [NCTL-1:0]   ctl_value,
  output var  logic              dist_sync_request
);

  typedef struct packed {
    mpr_phase_t             phase;
    logic [NPINS-1:0][7:0]  sel;
    logic [7:0]             sync1;
    logic [7:0]             sync2;
    logic [3:0]             div_cnt;
    logic                   div_clk;
    logic [5:0]             wd_cnt;
    logic [7:0]             strap;
    logic                   sync_owned;
    logic                   sync_prev;
    logic                   sync_pulse;
    logic [NCTL-1:0]        owned;
    logic [NCTL-1:0]        value;
    logic [7:0]             pout;
    logic [7:0]             rdata;
  } mpr_state_t;

  mpr_state_t st;
  mpr_state_t next_st;
  logic [NCODES-1:0] status_vec;
  logic              sync_level;

  // True when an input-mode code drives control index idx
  function automatic logic mpr_drives(input logic [6:0] code,
                                      input int unsigned idx);
    logic hit;
    hit = 1'b0;
    if (idx < CI_LOOP)
      hit = (code == 7'(IC_SYS + idx - CI_SYS));
    else if (idx < CI_OVR)
      hit = (code == 7'(IC_LOOP + idx - CI_LOOP));
    else if (idx < CI_TMO)
      hit = (code == 7'(IC_OVR + idx - CI_OVR));
    else if (idx < CI_EN)
      hit = (code == 7'(IC_TMO + idx - CI_TMO));
    else
      hit = (code == 7'(IC_EN + idx - CI_EN)) ||
            (code == 7'(IC_ENALL));
    return hit;
  endfunction : mpr_drives

  // Address decode of the select registers, shared by both writers
  function automatic logic mpr_hit(input logic [11:0] addr);
    return (addr >= FSEL_BASE) && (addr <= FSEL_LAST);
  endfunction : mpr_hit

  // Status sources by output code; codes left zero read low
  always_comb
  begin
    status_vec = '0;
    status_vec[OC_HIGH] = 1'b1;
    status_vec[OC_DIV]  = st.div_clk;
    status_vec[OC_WD]   = (st.wd_cnt != 6'h00);
    status_vec[OC_UPL]  = upload_busy;
    status_vec[OC_DNL]  = download_busy;
    status_vec[OC_LFLT] = loader_fault;
    status_vec[OC_LOCK] = system_clock_source_lock;
    status_vec[OC_CAL]  = system_clock_source_cal_busy;
    status_vec[OC_STBL] = system_clock_source_stable;
    status_vec[OC_LOOP +: NLOOP] = loop_status;
    status_vec[OC_FAULT +: 8] = ref_fault;
    status_vec[OC_VALID +: 8] = ref_valid;
    status_vec[OC_ACT +: 8]   = ref_active;
    status_vec[OC_SYNC] = dist_sync_status;
  end

  always_comb
  begin
    next_st = st;
    // Stage one feeds stage two only
    next_st.sync1 = pin_in;
    next_st.sync2 = st.sync1;
    // Straps are caught once, on the first edge after reset release
    if (st.phase == MPR_STRAP)
    begin
      next_st.strap = pin_in;
      next_st.phase = MPR_RUN;
    end
    // Host port wins a same-cycle collision with the loader
    if (st.phase == MPR_RUN)
    begin
      if (host_wr && mpr_hit(host_addr))
        next_st.sel[host_addr[2:0]] = host_wdata;
      else if (loader_wr && mpr_hit(loader_addr))
        next_st.sel[loader_addr[2:0]] = loader_wdata;
    end
    next_st.rdata = 8'h00;
    if (host_rd && mpr_hit(host_addr))
      next_st.rdata = st.sel[host_addr[2:0]];
    // Divider toggles every 16 cycles for a 32-cycle period
    next_st.div_cnt = st.div_cnt + 4'h1;
    if (st.div_cnt == DIV_LAST)
      next_st.div_clk = ~st.div_clk;
    // A timeout during a pulse restarts the full length
    if (watchdog_timeout)
      next_st.wd_cnt = WD_CYC;
    else if (st.wd_cnt != 6'h00)
      next_st.wd_cnt = st.wd_cnt - 6'h01;
    for (int p = 0; p < NPINS; p++)
    begin
      if (st.sel[p][MODE_BIT])
        next_st.pout[p] = status_vec[st.sel[p][6:0]];
      else
        next_st.pout[p] = 1'b0;
    end
    // Scan high to low so the lowest pin index is the final owner
    next_st.owned = '0;
    next_st.value = '0;
    for (int c = 0; c < NCTL; c++)
    begin
      for (int p = NPINS - 1; p >= 0; p--)
      begin
        if (!st.sel[p][MODE_BIT] && mpr_drives(st.sel[p][6:0], c))
        begin
          next_st.owned[c] = 1'b1;
          next_st.value[c] = st.sync2[p];
        end
      end
    end
    next_st.sync_owned = 1'b0;
    for (int p = NPINS - 1; p >= 0; p--)
    begin
      if (!st.sel[p][MODE_BIT] && st.sel[p][6:0] == 7'(IC_SYNC))
        next_st.sync_owned = 1'b1;
    end
    // Edge memory follows the chosen source; a change of owner may
    // look like an edge, so reprogram the pins while the line is high
    next_st.sync_prev = sync_level;
    next_st.sync_pulse = st.sync_owned && st.sync_prev &&
                         !sync_level;
  end

  // Level of the pin that currently owns the sync request
  always_comb
  begin
    sync_level = 1'b1;
    for (int p = NPINS - 1; p >= 0; p--)
    begin
      if (!st.sel[p][MODE_BIT] && st.sel[p][6:0] == 7'(IC_SYNC))
        sync_level = st.sync2[p];
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      st <= '0;
      st.phase <= MPR_STRAP;
      st.sel <= {NPINS{FSEL_RST}};
      st.sync_prev <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  always_comb
  begin
    for (int p = 0; p < NPINS; p++)
      pin_oe[p] = st.sel[p][MODE_BIT];
  end

  assign pin_out           = st.pout;
  assign host_rdata        = st.rdata;
  assign strap_value       = st.strap;
  assign strap_valid       = (st.phase == MPR_RUN);
  assign ctl_owned         = st.owned;
  assign ctl_value         = st.value;
  assign dist_sync_request = st.sync_pulse;

  out_mode_oe_a: assert property (@(posedge core_clk) disable iff (reset)
    (host_wr && host_addr == FSEL_BASE && host_wdata[MODE_BIT] &&
     st.phase == MPR_RUN) |=> pin_oe[0])
    else $error("pin 0 not driven after output mode write");

  in_mode_oe_a: assert property (@(posedge core_clk) disable iff (reset)
    (host_wr && host_addr == FSEL_LAST && !host_wdata[MODE_BIT] &&
     st.phase == MPR_RUN) |=> !pin_oe[7])
    else $error("pin 7 still driven in input mode");

  static_high_a: assert property (@(posedge core_clk) disable iff (reset)
    (st.sel[0] == 8'h81) |=> pin_out[0])
    else $error("static high code did not drive high");

  ref_fault_a: assert property (@(posedge core_clk) disable iff (reset)
    (st.sel[0] == 8'ha2) |=> (pin_out[0] == $past(ref_fault[2])))
    else $error("reference fault not routed");

  unused_low_a: assert property (@(posedge core_clk) disable iff (reset)
    (st.sel[0] == 8'h89) |=> !pin_out[0])
    else $error("unused output code not low");

  wd_pulse_a: assert property (@(posedge core_clk) disable iff (reset)
    $fell(st.wd_cnt != 6'h00) |-> $past(watchdog_timeout, 33))
    else $error("watchdog pulse length wrong");

  low_wins_a: assert property (@(posedge core_clk) disable iff (reset)
    (st.sel[0] != 8'h10 && st.sel[1] == 8'h10 && st.sel[3] == 8'h10) |=>
    (ctl_value[CI_LOOP] == $past(st.sync2[1])))
    else $error("lowest pin did not win the control");

  sync_edge_a: assert property (@(posedge core_clk) disable iff (reset)
    dist_sync_request |-> $past(st.sync_prev) && !$past(sync_level))
    else $error("sync request without falling edge");

  sync_delay_a: assert property (@(posedge core_clk) disable iff (reset)
    (st.sel[0] == 8'h10) ##1 (st.sel[0] == 8'h10) ##1 (st.sel[0] == 8'h10)
    |-> (ctl_value[CI_LOOP] == $past(pin_in[0], 3)))
    else $error("input level not delayed by synchroniser");

  strap_once_a: assert property (@(posedge core_clk) disable iff (reset)
    strap_valid |=> strap_valid && $stable(strap_value))
    else $error("strap value changed after capture");

  read_back_a: assert property (@(posedge core_clk)
    disable iff (reset) (host_rd && mpr_hit(host_addr)) |=>
    (host_rdata == $past(st.sel[host_addr[2:0]])))
    else $error("select register read back wrong");

  unmapped_read_a: assert property (@(posedge core_clk)
    disable iff (reset) (host_rd && !mpr_hit(host_addr)) |=>
    (host_rdata == 8'h00))
    else $error("unmapped read not zero");

  strap_hold_a: assert property (@(posedge core_clk)
    disable iff (reset) (st.phase == MPR_STRAP) |=> $stable(st.sel))
    else $error("select changed before strap capture");

  div_toggle_a: assert property (@(posedge core_clk)
    disable iff (reset) (st.div_cnt == DIV_LAST) |=>
    (st.div_clk != $past(st.div_clk)))
    else $error("divided clock missed its toggle");

  div_hold_a: assert property (@(posedge core_clk)
    disable iff (reset) (st.div_cnt != DIV_LAST) |=> $stable(st.div_clk))
    else $error("divided clock toggled early");

  wd_restart_a: assert property (@(posedge core_clk)
    disable iff (reset) watchdog_timeout |=> (st.wd_cnt == WD_CYC))
    else $error("watchdog pulse did not restart");

  // Output routing has no priority between pins, so pin 0 is checked alone
  loop_flag_a: assert property (@(posedge core_clk)
    disable iff (reset) (st.sel[0] == 8'h90) |=>
    (pin_out[0] == $past(loop_status[0])))
    else $error("loop status flag not routed");

  ref_valid_a: assert property (@(posedge core_clk)
    disable iff (reset) (st.sel[0] == 8'hb0) |=>
    (pin_out[0] == $past(ref_valid[0])))
    else $error("reference valid not routed");

  ref_active_a: assert property (@(posedge core_clk)
    disable iff (reset) (st.sel[0] == 8'hc0) |=>
    (pin_out[0] == $past(ref_active[0])))
    else $error("active reference not routed");

  input_low_a: assert property (@(posedge core_clk)
    disable iff (reset) !st.sel[0][MODE_BIT] |=> !pin_out[0])
    else $error("input mode pin driven high");

  idle_pins_a: assert property (@(posedge core_clk)
    disable iff (reset) (st.sel == '0) |=> (ctl_owned == '0))
    else $error("unused pins own a control");

  sys_control_a: assert property (@(posedge core_clk)
    disable iff (reset) (st.sel[0] == 8'h05) |=> (ctl_owned[CI_SYS + 4] &&
    ctl_value[CI_SYS + 4] == $past(st.sync2[0])))
    else $error("history reset control not routed");

  phase_step_a: assert property (@(posedge core_clk)
    disable iff (reset) (st.sel[0] == 8'h14) |=> ctl_owned[CI_LOOP + 4])
    else $error("phase decrement control not routed");

  monitor_override_a: assert property (@(posedge core_clk)
    disable iff (reset) (st.sel[0] == 8'h20) |=> (ctl_owned[CI_OVR] &&
    ctl_value[CI_OVR] == $past(st.sync2[0])))
    else $error("monitor override control not routed");

  force_timeout_a: assert property (@(posedge core_clk)
    disable iff (reset) (st.sel[0] == 8'h37) |=> ctl_owned[CI_TMO + 7])
    else $error("validation timeout control not routed");

  enable_all_a: assert property (@(posedge core_clk)
    disable iff (reset) (st.sel[0] == 8'h44) |=>
    (ctl_owned[CI_EN +: 4] == 4'hf))
    else $error("enable all did not take four channels");

endmodule : mpr_router
`default_nettype wire

// File: test/mpr_board.sv
// Board-side model of the logic around the general-purpose pins
`timescale 1ns/1ps
`default_nettype none
module mpr_board (
  input  wire logic [7:0] drive_lvl,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  output var  logic [7:0] pin_in
);
  // Board drives only released pins; a pin the device drives reads back
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : drive_lvl[i];
  end
endmodule : mpr_board
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the multifunction pin router
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mpr_pkg::*;
  logic            core_clk, reset, host_wr, host_rd, loader_wr;
  logic            watchdog_timeout, strap_valid, dist_sync_request, prv;
  logic [11:0]     host_addr, loader_addr;
  logic [7:0]      host_wdata, loader_wdata, drive_lvl, rdv, host_rdata;
  logic [7:0]      pin_in, pin_out, pin_oe, strap_value;
  logic [41:0]     stat;
  logic [NCTL-1:0] ctl_owned, ctl_value;
  int              bad_count, checks_done, n, m;

  mpr_router mpr_router_inst (.core_clk(core_clk), .reset(reset),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata),
    .loader_wr(loader_wr), .loader_addr(loader_addr),
    .loader_wdata(loader_wdata), .strap_value(strap_value),
    .strap_valid(strap_valid), .watchdog_timeout(watchdog_timeout),
    .upload_busy(stat[0]), .download_busy(stat[1]),
    .loader_fault(stat[2]), .system_clock_source_lock(stat[3]),
    .system_clock_source_cal_busy(stat[4]), .system_clock_source_stable(stat[5]),
    .loop_status(stat[16:6]), .ref_fault(stat[24:17]),
    .ref_valid(stat[32:25]), .ref_active(stat[40:33]),
    .dist_sync_status(stat[41]), .ctl_owned(ctl_owned),
    .ctl_value(ctl_value), .dist_sync_request(dist_sync_request));
  mpr_board mpr_board_inst (.drive_lvl(drive_lvl), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_in(pin_in));

  // Status bit that each output code should mirror; 99 means none
  function automatic int omap(int c);
    if (c >= 4 && c <= 8) return c - 4;
    if (c == OC_STBL) return 5;
    if (c >= 16 && c <= 26) return c - 10;
    if (c >= 32 && c <= 39) return c - 15;
    if (c >= 48 && c <= 55) return c - 23;
    if (c >= 64 && c <= 71) return c - 31;
    if (c == 80) return 41;
    return 99;
  endfunction : omap

  function automatic logic [29:0] imask(int c);
    if (c >= 1 && c <= 5) return 30'h1 << (c - 1);
    if (c >= 16 && c <= 20) return 30'h1 << (c - 11);
    if (c >= 32 && c <= 39) return 30'h1 << (c - 22);
    if (c >= 48 && c <= 55) return 30'h1 << (c - 30);
    if (c >= 64 && c <= 67) return 30'h1 << (c - 38);
    if (c == 68) return 30'h3c000000;
    return 30'h0;
  endfunction : imask

  task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic wr(logic [11:0] a, logic [7:0] d);
    @(posedge core_clk);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge core_clk);
    host_wr <= 1'b0;
  endtask : wr

  task automatic rd(logic [11:0] a);
    @(posedge core_clk);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge core_clk);
    host_rd <= 1'b0;
    #1 rdv = host_rdata;
  endtask : rd

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Whole sequence needs about 25k cycles; twice that means a hang
  initial
  begin
    #500000;
    bad_count++;
    end_of_test();
  end

  initial
  begin
    {reset, host_wr, host_rd, loader_wr, watchdog_timeout} = 5'h10;
    {host_addr, loader_addr, host_wdata, loader_wdata} = 40'h0;
    stat = 42'h0;
    drive_lvl = 8'ha5;
    repeat (5) @(posedge core_clk);
    chk("strap_valid", strap_valid, 1'b0);
    reset <= 1'b0;
    cyc(1);
    chk("strap", {strap_valid, strap_value}, 9'h1a5);
    for (int i = 0; i < 8; i++)
    begin
      rd(FSEL_BASE + 12'(i));
      chk("sel reset", rdv, FSEL_RST);
      wr(FSEL_BASE + 12'(i), 8'h80 | 8'(i));
      rd(FSEL_BASE + 12'(i));
      chk("sel", rdv, 8'h80 | 8'(i));
    end
    chk("oe", pin_oe, 8'hff);
    chk("levels", pin_out & 8'hf3, 8'h02);
    rd(12'h208);
    chk("unmapped", rdv, 8'h00);
    @(posedge core_clk);
    loader_wr <= 1'b1;
    loader_addr <= FSEL_BASE + 12'h3;
    loader_wdata <= 8'h10;
    @(posedge core_clk);
    loader_wr <= 1'b0;
    rd(FSEL_BASE + 12'h3);
    chk("loader", rdv, 8'h10);
    for (int i = 0; i < 8; i++)
      wr(FSEL_BASE + 12'(i), 8'h00);
    cyc(2);
    chk("oe off", pin_oe, 8'h00);
    for (int c = 0; c < 128; c++)
    begin
      if (c == OC_DIV || c == OC_WD)
        continue;
      wr(FSEL_BASE, 8'h80 | 8'(c));
      for (int j = 0; j < 43; j++)
      begin
        @(posedge core_clk);
        stat <= (j < 42) ? 42'h1 << j : 42'h0;
        cyc(3);
        chk("out", pin_out[0], c == OC_HIGH || omap(c) == j);
      end
      chk("owned", ctl_owned, 30'h0);
    end
    wr(FSEL_BASE, 8'h83);
    @(posedge core_clk);
    watchdog_timeout <= 1'b1;
    @(posedge core_clk);
    watchdog_timeout <= 1'b0;
    n = 0;
    repeat (45)
    begin
      cyc(1);
      n += pin_out[0];
    end
    chk("wd width", n, 32);
    wr(FSEL_BASE, 8'h82);
    cyc(2);
    n = 0;
    m = 0;
    prv = pin_out[0];
    repeat (64)
    begin
      cyc(1);
      n += pin_out[0];
      m += (pin_out[0] && !prv);
      prv = pin_out[0];
    end
    chk("div high", n, 32);
    chk("div rises", m, 2);
    for (int c = 0; c < 128; c++)
    begin
      wr(FSEL_BASE, 8'(c));
      @(posedge core_clk);
      drive_lvl <= 8'hff;
      cyc(4);
      chk("owned", ctl_owned, imask(c));
      chk("hi", ctl_value, imask(c));
      @(posedge core_clk);
      drive_lvl <= 8'h00;
      cyc(2);
      chk("lag", ctl_value, imask(c));
      cyc(2);
      chk("lo", ctl_value, 30'h0);
    end
    wr(FSEL_BASE, 8'(IC_SYNC));
    @(posedge core_clk);
    drive_lvl <= 8'hff;
    repeat (6) @(posedge core_clk);
    drive_lvl <= 8'h00;
    for (int k = 1; k < 12; k++)
    begin
      cyc(1);
      chk("sync", dist_sync_request, k == 3);
    end
    wr(FSEL_BASE, 8'h00);
    wr(FSEL_BASE + 12'h3, 8'(IC_LOOP));
    wr(FSEL_BASE + 12'h1, 8'(IC_LOOP));
    wr(FSEL_BASE + 12'h2, 8'(IC_ENALL));
    wr(FSEL_BASE + 12'h5, 8'(IC_EN));
    @(posedge core_clk);
    drive_lvl <= 8'h28;
    cyc(4);
    chk("prio own", ctl_owned, 30'h3c000020);
    chk("prio lo", ctl_value, 30'h0);
    @(posedge core_clk);
    drive_lvl <= 8'h06;
    cyc(4);
    chk("prio hi", ctl_value, 30'h3c000020);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
